// *** rtl/lmeim_defines.svh ***
`ifndef LMEIM_DEFINES_SVH
`define LMEIM_DEFINES_SVH

// Register indices, byte address is four times the index
`define LMEIM_IDX_LEN        6'h0f
`define LMEIM_IDX_DEACT      6'h12
`define LMEIM_IDX_MAINT      6'h13
`define LMEIM_IDX_MASK0      6'h14
`define LMEIM_IDX_MASK1      6'h15
`define LMEIM_IDX_EDGE       6'h16
`define LMEIM_IDX_STATUS     6'h18
`define LMEIM_IDX_CNT_LO     6'h1a
`define LMEIM_IDX_CNT_HI     6'h1b

// Maintenance control field positions
`define LMEIM_BIT_VIOL       6
`define LMEIM_BIT_LOGIC      5
`define LMEIM_BIT_ZDEF       4
`define LMEIM_BIT_SEL_HI     3
`define LMEIM_BIT_SEL_LO     2
`define LMEIM_BIT_MODE       1
`define LMEIM_BIT_TRF        0

// Reset values
`define LMEIM_RST_DEACT      8'h09
`define LMEIM_RST_LEN        2'h1
`define LMEIM_RST_MAINT      8'h00
`define LMEIM_RST_MASK       8'hff
`define LMEIM_RST_EDGE       8'h00

// Bus answers
`define LMEIM_RESP_OKAY      2'h0
`define LMEIM_RESP_SLVERR    2'h2

// Timing
`define LMEIM_CLK_PERIOD_NS  8
`define LMEIM_SECOND_NS      1000000000

`endif

// *** rtl/lmeim_pkg.sv ***
package lmeim_pkg;

  typedef enum logic [1:0] {
    LMEIM_SEL_PATTERN = 2'b00,
    LMEIM_SEL_ZERO    = 2'b01,
    LMEIM_SEL_VIOL    = 2'b10,
    LMEIM_SEL_BOTH    = 2'b11
  } lmeim_err_sel_t;

  typedef enum logic [1:0] {
    LMEIM_LEN_5 = 2'b00,
    LMEIM_LEN_6 = 2'b01,
    LMEIM_LEN_7 = 2'b10,
    LMEIM_LEN_8 = 2'b11
  } lmeim_len_t;

endpackage : lmeim_pkg

// *** rtl/lmeim_regbus_if.sv ***
`timescale 1ns/10ps
interface lmeim_regbus_if;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic       wr_hit;
  logic [5:0] rd_idx;
  logic [31:0] rd_data;
  logic       rd_hit;

  modport slave (output wr_en, output wr_idx, output wr_data, output wr_strb, input wr_hit,
                 output rd_idx, input rd_data, input rd_hit);
  modport regs  (input wr_en, input wr_idx, input wr_data, input wr_strb, output wr_hit,
                 input rd_idx, output rd_data, output rd_hit);
endinterface : lmeim_regbus_if

// *** rtl/lmeim_axil_slave.sv ***
`timescale 1ns/10ps
`include "lmeim_defines.svh"
module lmeim_axil_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  lmeim_regbus_if.slave    bus
);
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;

  // Address and data may arrive in either order
  assign do_write    = !awready && !wready && !bvalid;
  assign bus.wr_en   = do_write;
  assign bus.wr_idx  = awaddr_reg[7:2];
  assign bus.wr_data = wdata_reg;
  assign bus.wr_strb = wstrb_reg;
  assign bus.rd_idx  = araddr[7:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready    <= 1'b1;
      awaddr_reg <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      awready    <= 1'b0;
      awaddr_reg <= awaddr;
    end
    else if (do_write)
      awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready    <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      wready    <= 1'b0;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end
    else if (do_write)
      wready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= `LMEIM_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp  <= bus.wr_hit ? `LMEIM_RESP_OKAY : `LMEIM_RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // One read in flight; address is accepted only while no answer is pending
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `LMEIM_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= bus.rd_hit ? bus.rd_data : 32'h0000_0000;
      rresp   <= bus.rd_hit ? `LMEIM_RESP_OKAY : `LMEIM_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : lmeim_axil_slave

// *** rtl/lmeim_err_counter.sv ***
`timescale 1ns/10ps
`include "lmeim_defines.svh"
module lmeim_err_counter #(
  parameter int unsigned SECOND_CYCLES = `LMEIM_SECOND_NS / `LMEIM_CLK_PERIOD_NS
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire lmeim_pkg::lmeim_err_sel_t err_select,
  input  wire logic                    report_mode,
  input  wire logic                    transfer,
  input  wire logic                    pattern_err,
  input  wire logic                    zero_run,
  input  wire logic                    code_viol,
  output logic [15:0]                  count_result,
  output logic                         overflow,
  output logic                         second_tick
);
  logic [31:0] timer_reg;
  logic [15:0] count_reg;
  logic        inc;
  logic        take;

  always_comb
  begin
    case (err_select)
      lmeim_pkg::LMEIM_SEL_PATTERN: inc = pattern_err;
      lmeim_pkg::LMEIM_SEL_ZERO:    inc = zero_run;
      lmeim_pkg::LMEIM_SEL_VIOL:    inc = code_viol;
      lmeim_pkg::LMEIM_SEL_BOTH:    inc = code_viol || zero_run;
      default:                      inc = 1'b0;
    endcase
  end

  // One-second divider, one-cycle enable pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_reg   <= 32'h0000_0000;
      second_tick <= 1'b0;
    end
    else if (timer_reg == SECOND_CYCLES - 1)
    begin
      timer_reg   <= 32'h0000_0000;
      second_tick <= 1'b1;
    end
    else
    begin
      timer_reg   <= timer_reg + 32'h0000_0001;
      second_tick <= 1'b0;
    end
  end

  assign take = transfer || (report_mode && second_tick);

  // An error in the transfer cycle opens the new count, so none is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg    <= 16'h0000;
      count_result <= 16'h0000;
      overflow     <= 1'b0;
    end
    else
    begin
      overflow <= inc && !take && (count_reg == 16'hffff);
      if (take)
      begin
        count_result <= count_reg;
        count_reg    <= {15'h0000, inc};
      end
      else if (inc && count_reg != 16'hffff)
        count_reg <= count_reg + 16'h0001;
    end
  end
endmodule : lmeim_err_counter

// *** rtl/lmeim_top.sv ***
`timescale 1ns/10ps
`include "lmeim_defines.svh"
module lmeim_top #(
  parameter int unsigned SECOND_CYCLES = `LMEIM_SECOND_NS / `LMEIM_CLK_PERIOD_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic [7:0]  line_status,
  input  wire logic        shaper_overflow_evt,
  input  wire logic        jitter_over_evt,
  input  wire logic        jitter_under_evt,
  input  wire logic        pattern_error_evt,
  input  wire logic        zero_run_evt,
  input  wire logic        code_violation_evt,
  output logic [7:0]       rx_deact_pattern,
  output logic [1:0]       rx_deact_pattern_len,
  output logic             zero_run_definition,
  output logic             violation_insert,
  output logic             logic_error_insert,
  output logic             irq
);
  lmeim_regbus_if bus ();

  logic [7:0]  maint_reg;
  logic [7:0]  line_mask_reg;
  logic [7:0]  maint_mask_reg;
  logic [7:0]  edge_sel_reg;
  logic [7:0]  status_prev_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [15:0] status_set;
  logic [15:0] status_clr;
  logic [15:0] count_result;
  logic [7:0]  line_evt;
  logic [7:0]  maint_evt;
  logic        count_overflow;
  logic        second_tick;
  logic        transfer_pulse;
  logic        wr_byte0;
  logic        wr_deact;
  logic        wr_len;
  logic        wr_maint;
  logic        wr_mask0;
  logic        wr_mask1;
  logic        wr_edge;
  logic        wr_status;
  logic        irq_line;
  logic        irq_maint;
  logic [7:0]  line_rise;
  logic [7:0]  line_fall;
  logic        report_mode;
  lmeim_pkg::lmeim_err_sel_t err_select;

  function automatic logic reg_mapped(input logic [5:0] idx);
    case (idx)
      `LMEIM_IDX_LEN,
      `LMEIM_IDX_DEACT,
      `LMEIM_IDX_MAINT,
      `LMEIM_IDX_MASK0,
      `LMEIM_IDX_MASK1,
      `LMEIM_IDX_EDGE,
      `LMEIM_IDX_STATUS,
      `LMEIM_IDX_CNT_LO,
      `LMEIM_IDX_CNT_HI: reg_mapped = 1'b1;
      default:           reg_mapped = 1'b0;
    endcase
  endfunction : reg_mapped

  function automatic logic wr_rise(input logic [7:0] old_val, input logic [7:0] new_val, input int bitpos);
    wr_rise = !old_val[bitpos] && new_val[bitpos];
  endfunction : wr_rise

  // Byte lane helper; status is the only two-lane register
  function automatic logic [7:0] lane_clear(input logic strobe, input logic [7:0] data);
    lane_clear = strobe ? data : 8'h00;
  endfunction : lane_clear

  // Any event left unmasked in one byte
  function automatic logic unmasked_any(input logic [7:0] status, input logic [7:0] mask);
    unmasked_any = |(status & ~mask);
  endfunction : unmasked_any

  lmeim_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axil_awaddr),
    .awvalid (s_axil_awvalid),
    .awready (s_axil_awready),
    .wdata   (s_axil_wdata),
    .wstrb   (s_axil_wstrb),
    .wvalid  (s_axil_wvalid),
    .wready  (s_axil_wready),
    .bresp   (s_axil_bresp),
    .bvalid  (s_axil_bvalid),
    .bready  (s_axil_bready),
    .araddr  (s_axil_araddr),
    .arvalid (s_axil_arvalid),
    .arready (s_axil_arready),
    .rdata   (s_axil_rdata),
    .rresp   (s_axil_rresp),
    .rvalid  (s_axil_rvalid),
    .rready  (s_axil_rready),
    .bus     (bus.slave)
  );

  assign bus.wr_hit = reg_mapped(bus.wr_idx);
  assign bus.rd_hit = reg_mapped(bus.rd_idx);
  // Registers are one byte wide; only lane 0 (and lane 1 of status) carry data
  assign wr_byte0   = bus.wr_en && bus.wr_strb[0];

  // One select per writable register (none for the count bytes); status clears by lane, so it skips the byte-0 gate
  assign wr_deact  = wr_byte0 && bus.wr_idx == `LMEIM_IDX_DEACT;
  assign wr_len    = wr_byte0 && bus.wr_idx == `LMEIM_IDX_LEN;
  assign wr_maint  = wr_byte0 && bus.wr_idx == `LMEIM_IDX_MAINT;
  assign wr_mask0  = wr_byte0 && bus.wr_idx == `LMEIM_IDX_MASK0;
  assign wr_mask1  = wr_byte0 && bus.wr_idx == `LMEIM_IDX_MASK1;
  assign wr_edge   = wr_byte0 && bus.wr_idx == `LMEIM_IDX_EDGE;
  assign wr_status = bus.wr_en && bus.wr_idx == `LMEIM_IDX_STATUS;

  // Read mux, unused upper bits read zero
  always_comb
  begin
    bus.rd_data = 32'h0000_0000;
    case (bus.rd_idx)
      `LMEIM_IDX_LEN:    bus.rd_data[1:0]  = rx_deact_pattern_len;
      `LMEIM_IDX_DEACT:  bus.rd_data[7:0]  = rx_deact_pattern;
      `LMEIM_IDX_MAINT:  bus.rd_data[7:0]  = maint_reg;
      `LMEIM_IDX_MASK0:  bus.rd_data[7:0]  = line_mask_reg;
      `LMEIM_IDX_MASK1:  bus.rd_data[7:0]  = maint_mask_reg;
      `LMEIM_IDX_EDGE:   bus.rd_data[7:0]  = edge_sel_reg;
      `LMEIM_IDX_STATUS: bus.rd_data[15:0] = status_reg;
      `LMEIM_IDX_CNT_LO: bus.rd_data[7:0]  = count_result[7:0];
      `LMEIM_IDX_CNT_HI: bus.rd_data[7:0]  = count_result[15:8];
      default:           bus.rd_data       = 32'h0000_0000;
    endcase
  end

  // Deactivate code
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_deact_pattern <= `LMEIM_RST_DEACT;
    else if (wr_deact)
      rx_deact_pattern <= bus.wr_data[7:0];
  end

  // Code length, six bits after reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_deact_pattern_len <= `LMEIM_RST_LEN;
    else if (wr_len)
      rx_deact_pattern_len <= bus.wr_data[1:0];
  end

  // Maintenance control; bit 7 reserved and kept zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      maint_reg <= `LMEIM_RST_MAINT;
    else if (wr_maint)
      maint_reg <= {1'b0, bus.wr_data[6:0]};
  end

  // Counter controls come straight from the maintenance byte
  assign err_select  = lmeim_pkg::lmeim_err_sel_t'(maint_reg[`LMEIM_BIT_SEL_HI:`LMEIM_BIT_SEL_LO]);
  assign report_mode = maint_reg[`LMEIM_BIT_MODE];

  // Zero-run criterion follows its control bit one cycle late
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      zero_run_definition <= 1'b0;
    else
      zero_run_definition <= maint_reg[`LMEIM_BIT_ZDEF];
  end

  // Insertion and transfer act only on a written 0 to 1 change; a held one does nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      violation_insert <= 1'b0;
    else
      violation_insert <= wr_maint && wr_rise(maint_reg, bus.wr_data[7:0], `LMEIM_BIT_VIOL);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      logic_error_insert <= 1'b0;
    else
      logic_error_insert <= wr_maint && wr_rise(maint_reg, bus.wr_data[7:0], `LMEIM_BIT_LOGIC);
  end

  // Manual transfer is honoured in either mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      transfer_pulse <= 1'b0;
    else
      transfer_pulse <= wr_maint && wr_rise(maint_reg, bus.wr_data[7:0], `LMEIM_BIT_TRF);
  end

  // Counter keeps the one-second divider with it
  lmeim_err_counter #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_counter (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .err_select   (err_select),
    .report_mode  (report_mode),
    .transfer     (transfer_pulse),
    .pattern_err  (pattern_error_evt),
    .zero_run     (zero_run_evt),
    .code_viol    (code_violation_evt),
    .count_result (count_result),
    .overflow     (count_overflow),
    .second_tick  (second_tick)
  );

  // Masks start all ones so nothing interrupts before software opts in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_mask_reg <= `LMEIM_RST_MASK;
    else if (wr_mask0)
      line_mask_reg <= bus.wr_data[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      maint_mask_reg <= `LMEIM_RST_MASK;
    else if (wr_mask1)
      maint_mask_reg <= bus.wr_data[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      edge_sel_reg <= `LMEIM_RST_EDGE;
    else if (wr_edge)
      edge_sel_reg <= bus.wr_data[7:0];
  end

  // Status inputs share this clock, so no synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_prev_reg <= 8'h00;
    else
      status_prev_reg <= line_status;
  end

  assign line_rise = line_status & ~status_prev_reg;
  assign line_fall = ~line_status & status_prev_reg;
  // Falling edges count only where the edge select bit is set
  assign line_evt  = line_rise | (edge_sel_reg & line_fall);

  // Maintenance events arrive as one-cycle pulses
  assign maint_evt = {shaper_overflow_evt,
                      jitter_over_evt,
                      jitter_under_evt,
                      pattern_error_evt,
                      zero_run_evt,
                      code_violation_evt,
                      second_tick,
                      count_overflow};

  assign status_set = {maint_evt, line_evt};

  // Each byte of status clears under its own write strobe
  always_comb
  begin
    status_clr = 16'h0000;
    if (wr_status)
    begin
      status_clr[7:0]  = lane_clear(bus.wr_strb[0], bus.wr_data[7:0]);
      status_clr[15:8] = lane_clear(bus.wr_strb[1], bus.wr_data[15:8]);
    end
  end

  // A new event beats a clear in the same cycle
  assign status_next = (status_reg & ~status_clr) | status_set;

  // Sticky status, cleared only by writing ones
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= 16'h0000;
    else
      status_reg <= status_next;
  end

  // Mask one blocks the event, mask zero passes it
  assign irq_line  = unmasked_any(status_reg[7:0], line_mask_reg);
  assign irq_maint = unmasked_any(status_reg[15:8], maint_mask_reg);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= irq_line || irq_maint;
  end
endmodule : lmeim_top

// *** verification/lmeim_top_assertions.sv ***
`timescale 1ns/10ps
module lmeim_top_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axil_awvalid,
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0]  s_axil_rresp,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire logic [7:0]  rx_deact_pattern,
  input wire logic [1:0]  rx_deact_pattern_len,
  input wire logic        zero_run_definition,
  input wire logic        violation_insert,
  input wire logic        logic_error_insert,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  b_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped early");
  wr_resp_a: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##2 s_axil_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read response late");
  ar_block_a: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("read address taken during response");
  err_data_a: assert property (s_axil_rvalid && s_axil_rresp == 2'h2 |-> s_axil_rdata == 32'h0)
    else $error("error read carries data");
  reset_vals_a: assert property ($rose(aresetn) |-> rx_deact_pattern == 8'h09 && rx_deact_pattern_len == 2'h1 && !irq)
    else $error("bad value after reset");
  // Code and length outputs move only on the write edge that raises the response; zero-run definition moves one edge later
  pattern_write_a: assert property ($changed(rx_deact_pattern) |-> s_axil_bvalid && s_axil_bresp == 2'h0)
    else $error("deactivate code moved without write");
  len_write_a: assert property ($changed(rx_deact_pattern_len) |-> s_axil_bvalid && s_axil_bresp == 2'h0)
    else $error("code length moved without write");
  zdef_write_a: assert property ($changed(zero_run_definition) |-> $past(s_axil_bvalid))
    else $error("zero-run definition moved without write");
  viol_pulse_a: assert property (violation_insert |=> !violation_insert)
    else $error("violation insert longer than one cycle");
  logic_pulse_a: assert property (logic_error_insert |=> !logic_error_insert)
    else $error("logic error insert longer than one cycle");
endmodule : lmeim_top_assertions

bind lmeim_top lmeim_top_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
  .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
  .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_arvalid(s_axil_arvalid),
  .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .rx_deact_pattern(rx_deact_pattern),
  .rx_deact_pattern_len(rx_deact_pattern_len), .zero_run_definition(zero_run_definition),
  .violation_insert(violation_insert), .logic_error_insert(logic_error_insert), .irq(irq));

// *** verification/lmeim_tb_top.sv ***
`timescale 1ns/10ps
module lmeim_tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  line_status = 8'h00;
  logic [5:0]  evt = 6'h00;
  logic        awready, wready, bvalid, arready, rvalid, zero_run_definition, violation_insert;
  logic        logic_error_insert, irq;
  logic [1:0]  bresp, rresp, rx_deact_pattern_len;
  logic [31:0] rdata;
  logic [7:0]  rx_deact_pattern;
  int          n_errors = 0, checks_done = 0, n_viol = 0, n_logic = 0;

  // Short second keeps the automatic report within a few hundred cycles
  lmeim_top #(.SECOND_CYCLES(200)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .line_status(line_status),
    .shaper_overflow_evt(evt[5]), .jitter_over_evt(evt[4]), .jitter_under_evt(evt[3]),
    .pattern_error_evt(evt[2]), .zero_run_evt(evt[1]), .code_violation_evt(evt[0]),
    .rx_deact_pattern(rx_deact_pattern), .rx_deact_pattern_len(rx_deact_pattern_len),
    .zero_run_definition(zero_run_definition), .violation_insert(violation_insert),
    .logic_error_insert(logic_error_insert), .irq(irq));

  always #4 aclk = ~aclk;

  always @(posedge aclk)
  begin
    n_viol  <= n_viol + violation_insert;
    n_logic <= n_logic + logic_error_insert;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rsp;
    wr(a, d, rsp);
    chk("write response", rsp, 2'h0);
  endtask : w

  task automatic r(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  rsp;
    rd(a, d, rsp);
    chk("read response", rsp, 2'h0);
    chk(what, d, exp);
  endtask : r

  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge aclk) evt[k] <= 1'b1;
      @(posedge aclk) evt[k] <= 1'b0;
    end
  endtask : pulse

  task automatic settle_chk(input string what, input logic seen_now, input logic exp);
    repeat (3) @(posedge aclk);
    chk(what, irq, exp);
  endtask : settle_chk

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  rsp;
    r(8'h48, 32'h09, "deactivate code");
    r(8'h3c, 32'h01, "code length");
    r(8'h50, 32'hff, "line mask");
    r(8'h54, 32'hff, "maint mask");
    chk("code length port", rx_deact_pattern_len, 2'h1);
    wr(8'h7c, 32'h5, rsp);
    chk("unmapped write", rsp, 2'h2);
    rd(8'h7c, d, rsp);
    chk("unmapped read", {rsp, d[29:0]}, 32'h80000000);
  endtask : t_reset

  task automatic t_pattern;
    for (int i = 0; i < 4; i++)
    begin
      w(8'h48, 32'h96 ^ i);
      w(8'h3c, i);
      r(8'h48, 32'h96 ^ i, "deactivate code");
      chk("deactivate code port", rx_deact_pattern, 32'h96 ^ i);
      chk("code length port", rx_deact_pattern_len, i);
    end
  endtask : t_pattern

  task automatic t_insert;
    int v0, l0;
    for (int b = 5; b < 7; b++)
    begin
      v0 = n_viol;
      l0 = n_logic;
      w(8'h4c, 32'h1 << b);
      w(8'h4c, 32'h1 << b);
      w(8'h4c, 32'h0);
      w(8'h4c, 32'h1 << b);
      repeat (4) @(posedge aclk);
      chk("violation pulses", n_viol - v0, b == 6 ? 2 : 0);
      chk("logic error pulses", n_logic - l0, b == 5 ? 2 : 0);
    end
    w(8'h4c, 32'h10);
    repeat (3) @(posedge aclk);
    chk("zero-run definition", zero_run_definition, 1'b1);
    w(8'h4c, 32'h0);
    repeat (3) @(posedge aclk);
    chk("zero-run definition", zero_run_definition, 1'b0);
  endtask : t_insert

  task automatic t_count;
    logic [31:0] d;
    logic [1:0]  rsp;
    for (int s = 0; s < 4; s++)
    begin
      w(8'h4c, s << 2);
      pulse(2, 1);
      pulse(1, 2);
      pulse(0, 4);
      w(8'h4c, (s << 2) | 1);
      r(8'h68, s == 0 ? 1 : s == 1 ? 2 : s == 2 ? 4 : 6, "count low");
      r(8'h6c, 32'h0, "count high");
    end
    // Tick phase is unknown, so align on one before counting
    w(8'h4c, 32'h0a);
    w(8'h60, 32'h200);
    do rd(8'h60, d, rsp); while (d[9] !== 1'b1);
    w(8'h60, 32'h200);
    pulse(0, 5);
    do rd(8'h60, d, rsp); while (d[9] !== 1'b1);
    r(8'h68, 32'h5, "automatic count");
    w(8'h4c, 32'h0);
  endtask : t_count

  task automatic t_irq;
    logic [15:0] m;
    @(posedge aclk);
    line_status <= 8'hf7;
    evt         <= 6'h37;
    @(posedge aclk);
    evt <= 6'h00;
    settle_chk("irq all masked", irq, 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      if (i == 8 || i == 9) continue;
      m = ~(16'h1 << i);
      w(8'h50, m[7:0]);
      w(8'h54, m[15:8]);
      settle_chk("irq one source", irq, i != 3 && i != 13);
    end
    w(8'h54, 32'hff);
    w(8'h50, 32'hfe);
    w(8'h60, 32'hffff);
    settle_chk("irq after clear", irq, 1'b0);
    @(posedge aclk) line_status[0] <= 1'b0;
    settle_chk("irq falling ignored", irq, 1'b0);
    @(posedge aclk) line_status[0] <= 1'b1;
    settle_chk("irq on rise", irq, 1'b1);
    w(8'h60, 32'h1);
    w(8'h58, 32'h1);
    settle_chk("irq cleared", irq, 1'b0);
    @(posedge aclk) line_status[0] <= 1'b0;
    settle_chk("irq on fall", irq, 1'b1);
    w(8'h50, 32'hff);
    w(8'h54, 32'hfd);
    repeat (200) @(posedge aclk);
    settle_chk("irq on second tick", irq, 1'b1);
  endtask : t_irq

  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict;
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_pattern;
    t_insert;
    t_count;
    t_irq;
    print_verdict;
  end
endmodule : lmeim_tb_top
